// ===== rtl/ts_capture_pkg.sv
// Purpose: Constants and types of the port timestamp capture unit
// Assumes: 100 MHz core clock, APB access, byte address = 4 x index
// Notes:
// Function
// - Freeze holds captures and clears ready
// - Capture only on ports with enable set
// - Line mode captures at trigger line number
// - Free-run frame mode waits for trigger line
// - Ready flag bit 4, cleared by freeze
// - Per-port valid bits 0 and 1
// - Port 0 result as two bytes
// - Port 1 result as two bytes
// - Event select: line start or frame start
// - Counter frame-sync referenced or free running
// - Frame-sync edge: rising or falling
package ts_capture_pkg;

  localparam int NPORT = 2;

  // Register indexes
  localparam logic [5:0] IDX_CONFIG   = 6'h25;
  localparam logic [5:0] IDX_CONTROL  = 6'h26;
  localparam logic [5:0] IDX_LINE_HI  = 6'h27;
  localparam logic [5:0] IDX_LINE_LO  = 6'h28;
  localparam logic [5:0] IDX_STATUS   = 6'h29;
  localparam logic [5:0] IDX_P0_HI    = 6'h2a;
  localparam logic [5:0] IDX_P0_LO    = 6'h2b;
  localparam logic [5:0] IDX_P1_HI    = 6'h2c;
  localparam logic [5:0] IDX_P1_LO    = 6'h2d;
  localparam logic [5:0] IDX_IRQ_STS  = 6'h38;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h39;

  // Field positions
  localparam int CTL_FREEZE_BIT = 4;
  localparam int CFG_EDGE_BIT   = 6;
  localparam int CFG_RES_LSB    = 4;
  localparam int CFG_FREE_BIT   = 1;
  localparam int CFG_EVT_BIT    = 0;
  localparam int STS_READY_BIT  = 4;

  // Tick periods
  localparam int CLK_NS   = 10;
  localparam int RES0_NS  = 40;
  localparam int RES1_NS  = 80;
  localparam int RES2_NS  = 160;
  localparam int RES3_NS  = 1000;
  localparam logic [6:0] RES0_CYC = 7'(RES0_NS / CLK_NS);
  localparam logic [6:0] RES1_CYC = 7'(RES1_NS / CLK_NS);
  localparam logic [6:0] RES2_CYC = 7'(RES2_NS / CLK_NS);
  localparam logic [6:0] RES3_CYC = 7'(RES3_NS / CLK_NS);

  typedef enum logic {ARM_WAIT, ARM_ARMED} arm_t;

  typedef struct packed {
    logic [NPORT-1:0] frame_start;
    logic [NPORT-1:0] line_start;
  } video_in_t;

  typedef struct packed {
    logic [NPORT-1:0]        enable;
    logic                    freeze;
    logic [7:0]              line_hi;
    logic [7:0]              line_lo;
    logic                    evt_sel;
    logic                    freerun;
    logic [1:0]              res_sel;
    logic                    edge_sel;
    logic [NPORT-1:0]        valid;
    logic                    ready;
    logic [NPORT-1:0][15:0]  result;
    logic [NPORT-1:0][15:0]  line_cnt;
    arm_t [NPORT-1:0]        arm;
    logic [6:0]              div_cnt;
    logic [15:0]             tick_cnt;
    logic                    fsync_q;
    logic [7:0]              irq_sts;
    logic [7:0]              irq_mask;
    logic [31:0]             prdata;
    logic                    pslverr;
  } state_t;

endpackage

// ===== rtl/rx_port_timestamp_capture.sv
// Purpose: Per-port timestamp capture with APB registers
// Assumes: Video and frame-sync inputs synchronous to mclk
// Notes: Zero-wait APB slave, read data staged in setup phase
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module rx_port_timestamp_capture (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      frame_sync,
  input  wire ts_capture_pkg::video_in_t video,
  output logic                           irq
);

  ts_capture_pkg::state_t s_r;
  ts_capture_pkg::state_t s_nxt;
  logic                   wr_en;
  logic                   rd_setup;
  logic [5:0]             idx;
  logic [6:0]             period;
  logic                   tick_en;
  logic                   fs_edge;
  logic [15:0]            trig_line;
  logic [1:0][15:0]       line_inc;
  logic [1:0]             hit;
  logic [1:0]             cap;
  logic [7:0]             evt;
  logic [7:0]             rdata;
  logic                   mapped;

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    s_nxt = s_r;
    idx = paddr[7:2];
    wr_en = psel & penable & pwrite & pstrb[0];
    rd_setup = psel & ~penable;
    trig_line = {s_r.line_hi, s_r.line_lo};

    // Register writes
    if (wr_en)
    begin
      case (idx)
        ts_capture_pkg::IDX_CONFIG:
        begin
          s_nxt.edge_sel = pwdata[ts_capture_pkg::CFG_EDGE_BIT];
          s_nxt.res_sel =
            pwdata[ts_capture_pkg::CFG_RES_LSB +: 2];
          s_nxt.freerun = pwdata[ts_capture_pkg::CFG_FREE_BIT];
          s_nxt.evt_sel = pwdata[ts_capture_pkg::CFG_EVT_BIT];
        end
        ts_capture_pkg::IDX_CONTROL:
        begin
          s_nxt.freeze = pwdata[ts_capture_pkg::CTL_FREEZE_BIT];
          s_nxt.enable = pwdata[1:0];
        end
        ts_capture_pkg::IDX_LINE_HI:  s_nxt.line_hi = pwdata[7:0];
        ts_capture_pkg::IDX_LINE_LO:  s_nxt.line_lo = pwdata[7:0];
        ts_capture_pkg::IDX_IRQ_MASK: s_nxt.irq_mask = pwdata[7:0];
        default:                      s_nxt.line_hi = s_r.line_hi;
      endcase
    end

    // Tick divider
    case (s_r.res_sel)
      2'h0:    period = ts_capture_pkg::RES0_CYC;
      2'h1:    period = ts_capture_pkg::RES1_CYC;
      2'h2:    period = ts_capture_pkg::RES2_CYC;
      default: period = ts_capture_pkg::RES3_CYC;
    endcase
    tick_en = (s_r.div_cnt >= period - 7'h01);

    // Frame-sync active edge
    fs_edge = s_r.edge_sel ? (s_r.fsync_q & ~frame_sync)
                           : (~s_r.fsync_q & frame_sync);
    s_nxt.fsync_q = frame_sync;

    if (!s_r.freerun && fs_edge)
    begin
      s_nxt.tick_cnt = 16'h0000;
      s_nxt.div_cnt = 7'h00;
    end
    else if (tick_en)
    begin
      s_nxt.tick_cnt = s_r.tick_cnt + 16'h0001;
      s_nxt.div_cnt = 7'h00;
    end
    else
    begin
      s_nxt.div_cnt = s_r.div_cnt + 7'h01;
    end

    // Resume after freeze starts a fresh capture round
    if (s_r.freeze && !s_nxt.freeze)
    begin
      s_nxt.valid = '0;
    end

    // Per-port line tracking and capture
    for (int p = 0; p < ts_capture_pkg::NPORT; p++)
    begin
      line_inc[p] = s_r.line_cnt[p] + 16'h0001;
      hit[p] = video.line_start[p] & (line_inc[p] == trig_line);
      if (video.frame_start[p])
      begin
        s_nxt.line_cnt[p] = 16'h0000;
      end
      else if (video.line_start[p])
      begin
        s_nxt.line_cnt[p] = line_inc[p];
      end
      if (!s_r.evt_sel)
      begin
        cap[p] = hit[p];
      end
      else if (!s_r.freerun)
      begin
        cap[p] = video.frame_start[p];
      end
      else
      begin
        cap[p] = video.frame_start[p]
                 & (s_r.arm[p] == ts_capture_pkg::ARM_ARMED);
      end
      if (s_r.evt_sel && s_r.freerun)
      begin
        if (cap[p])
        begin
          s_nxt.arm[p] = ts_capture_pkg::ARM_WAIT;
        end
        else if (hit[p])
        begin
          s_nxt.arm[p] = ts_capture_pkg::ARM_ARMED;
        end
      end
      else
      begin
        s_nxt.arm[p] = ts_capture_pkg::ARM_WAIT;
      end
      cap[p] = cap[p] & s_r.enable[p]
               & ~s_nxt.freeze;
      if (cap[p])
      begin
        s_nxt.result[p] = s_r.tick_cnt;
        s_nxt.valid[p] = 1'h1;
      end
    end

    // Ready flag
    if (s_nxt.freeze)
    begin
      s_nxt.ready = 1'h0;
    end
    else if ((|s_nxt.enable)
             && ((s_nxt.valid & s_nxt.enable) == s_nxt.enable))
    begin
      s_nxt.ready = 1'h1;
    end

    // Interrupt status, set wins over write-one-to-clear
    evt = 8'h00;
    evt[1:0] = cap;
    evt[ts_capture_pkg::STS_READY_BIT] = s_nxt.ready & ~s_r.ready;
    s_nxt.irq_sts = s_r.irq_sts | evt;
    if (wr_en && idx == ts_capture_pkg::IDX_IRQ_STS)
    begin
      s_nxt.irq_sts = (s_r.irq_sts & ~pwdata[7:0]) | evt;
    end

    // Read mux
    rdata = 8'h00;
    mapped = 1'h1;
    case (idx)
      ts_capture_pkg::IDX_CONFIG:
      begin
        rdata[ts_capture_pkg::CFG_EDGE_BIT] = s_r.edge_sel;
        rdata[ts_capture_pkg::CFG_RES_LSB +: 2] = s_r.res_sel;
        rdata[ts_capture_pkg::CFG_FREE_BIT] = s_r.freerun;
        rdata[ts_capture_pkg::CFG_EVT_BIT] = s_r.evt_sel;
      end
      ts_capture_pkg::IDX_CONTROL:
      begin
        rdata[ts_capture_pkg::CTL_FREEZE_BIT] = s_r.freeze;
        rdata[1:0] = s_r.enable;
      end
      ts_capture_pkg::IDX_LINE_HI:  rdata = s_r.line_hi;
      ts_capture_pkg::IDX_LINE_LO:  rdata = s_r.line_lo;
      ts_capture_pkg::IDX_STATUS:
      begin
        rdata[ts_capture_pkg::STS_READY_BIT] = s_r.ready;
        rdata[1:0] = s_r.valid;
      end
      ts_capture_pkg::IDX_P0_HI: rdata = s_r.result[0][15:8];
      ts_capture_pkg::IDX_P0_LO: rdata = s_r.result[0][7:0];
      ts_capture_pkg::IDX_P1_HI: rdata = s_r.result[1][15:8];
      ts_capture_pkg::IDX_P1_LO: rdata = s_r.result[1][7:0];
      ts_capture_pkg::IDX_IRQ_STS:  rdata = s_r.irq_sts;
      ts_capture_pkg::IDX_IRQ_MASK: rdata = s_r.irq_mask;
      default:                      mapped = 1'h0;
    endcase
    s_nxt.pslverr = 1'h0;
    if (rd_setup)
    begin
      s_nxt.prdata = {24'h000000, rdata};
      s_nxt.pslverr = ~mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign prdata  = s_r.prdata;
  assign pslverr = s_r.pslverr;
  assign pready  = psel & penable;
  assign irq     = |(s_r.irq_sts & s_r.irq_mask);

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  AST_FREEZE_READY:
  assert property ((wr_en && idx == ts_capture_pkg::IDX_CONTROL
                    && pwdata[ts_capture_pkg::CTL_FREEZE_BIT])
                   |=> (s_r.freeze && !s_r.ready))
    else $error("Freeze write did not clear ready");

  AST_FREEZE_HOLD:
  assert property ((s_r.freeze && s_nxt.freeze)
                   |=> $stable(s_r.result) && $stable(s_r.valid))
    else $error("Captures changed while frozen");

  AST_DISABLED_PORT:
  assert property ((!s_r.enable[0] && !s_nxt.enable[0])
                   |=> $stable(s_r.result[0]))
    else $error("Disabled port captured");

  AST_LINE_CAPTURE:
  assert property ((!s_r.evt_sel && s_r.enable[0] && !s_r.freeze
                    && !wr_en && video.line_start[0]
                    && !video.frame_start[0]
                    && s_r.line_cnt[0] + 16'h0001 == trig_line)
                   |=> (s_r.valid[0]
                        && s_r.result[0] == $past(s_r.tick_cnt)))
    else $error("Line-start capture missed");

  AST_ARM_WAIT:
  assert property ((s_r.evt_sel && s_r.freerun && !wr_en
                    && s_r.arm[1] == ts_capture_pkg::ARM_WAIT)
                   |=> $stable(s_r.result[1]))
    else $error("Frame capture before trigger line");

  AST_FRAME_CAPTURE:
  assert property ((s_r.evt_sel && !s_r.freerun && s_r.enable[1]
                    && !s_r.freeze && !wr_en
                    && video.frame_start[1])
                   |=> (s_r.valid[1]
                        && s_r.result[1] == $past(s_r.tick_cnt)))
    else $error("Frame-start capture missed");

  AST_READY_FROZEN:
  assert property (s_r.freeze |-> !s_r.ready)
    else $error("Ready seen while frozen");

  AST_VALID_CAUSE:
  assert property ($rose(s_r.valid[1])
                   |-> $past(video.line_start[1]
                             | video.frame_start[1]))
    else $error("Valid set without video event");

  AST_P0_UPPER_READ:
  assert property ((rd_setup && !pwrite
                    && idx == ts_capture_pkg::IDX_P0_HI)
                   |=> prdata[7:0] == $past(s_r.result[0][15:8]))
    else $error("Port 0 upper byte read wrong");

  AST_P1_LOWER_READ:
  assert property ((rd_setup && !pwrite
                    && idx == ts_capture_pkg::IDX_P1_LO)
                   |=> prdata == {24'h000000, $past(s_r.result[1][7:0])})
    else $error("Port 1 lower byte read wrong");

  AST_TICK_40NS:
  assert property ((tick_en && s_r.res_sel == 2'h0 && s_r.freerun
                    && !wr_en)
                   |=> (!tick_en)[*3] ##1 tick_en)
    else $error("Tick period not four cycles");

  AST_SYNC_RESET:
  assert property ((!s_r.freerun && !s_r.edge_sel
                    && !s_r.fsync_q && frame_sync)
                   |=> s_r.tick_cnt == 16'h0000)
    else $error("Counter not cleared on frame sync");

  AST_READY_ALL:
  assert property ($rose(s_r.ready)
                   |-> ((s_r.valid & s_r.enable) == s_r.enable)
                       && (|s_r.enable))
    else $error("Ready before all enabled ports valid");

endmodule
`default_nettype wire

// ===== sim/test_rx_port_timestamp_capture.sv
// Purpose: Self-checking bench for the port timestamp capture unit
// Assumes: Zero-wait APB slave, video pulses synchronous to mclk
// Notes: Results are sampled mid tick period so edge skew cancels
`timescale 1ns/1ps
`default_nettype none
module test_rx_port_timestamp_capture;
  logic                      mclk;
  logic                      rst_n;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [7:0]                paddr;
  logic [31:0]               pwdata;
  logic [3:0]                pstrb;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      frame_sync;
  ts_capture_pkg::video_in_t video;
  logic                      irq;
  logic [31:0]               rd;
  logic                      err;
  logic                      edge_fall;
  int                        fails = 0;
  int                        checks = 0;
  int                        cyc = 0;
  int                        per [4] = '{4, 8, 16, 100};
  int                        kk [4] = '{300, 5, 3, 2};
  logic [5:0]                idx_all [11] = '{6'h25, 6'h26, 6'h27,
    6'h28, 6'h29, 6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h38, 6'h39};

  rx_port_timestamp_capture dut (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .pstrb      (pstrb),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .frame_sync (frame_sync),
    .video      (video),
    .irq        (irq)
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////
  task final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      final_report();
    end
  end

  task check(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; ends one idle cycle after the access edge
  task apb(input logic is_wr, input logic [5:0] idx,
           input logic [7:0] wd);
    psel    <= 1'b1;
    pwrite  <= is_wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge mclk);
    check("setup ready", {31'h0, pready}, 32'h0);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task expect_reg(input string name, input logic [5:0] idx,
                  input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(name, rd, exp);
  endtask

  // Freeze then unfreeze so valid bits start clear
  task rearm(input logic [7:0] cfg, input logic [1:0] en);
    wr(ts_capture_pkg::IDX_CONFIG, cfg);
    wr(ts_capture_pkg::IDX_CONTROL, {3'b000, 1'b1, 2'b00, en});
    wr(ts_capture_pkg::IDX_CONTROL, {6'h00, en});
  endtask

  // Sync edge, then trigger event at k periods plus half a period
  task run(input logic [1:0] mask, input logic evt, input int p,
           input int k, input int t);
    int last;
    last = p * k + p / 2;
    frame_sync        <= ~edge_fall;
    video.frame_start <= evt ? 2'b00 : mask;
    for (int j = 1; j <= last; j++)
    begin
      @(posedge mclk);
      video.line_start  <= (!evt && j > last - t) ? mask : 2'b00;
      video.frame_start <= (evt && j == last) ? mask : 2'b00;
    end
    @(posedge mclk);
    video      <= '0;
    frame_sync <= edge_fall;
    @(posedge mclk);
  endtask

  task pulse(input logic [1:0] fsm, input logic [1:0] lsm);
    video.frame_start <= fsm;
    video.line_start  <= lsm;
    @(posedge mclk);
    video <= '0;
    @(posedge mclk);
  endtask

  //////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h1;
    frame_sync = 1'b0;
    video = '0;
    edge_fall = 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    foreach (idx_all[i])
      expect_reg("reset value", idx_all[i], 32'h0);
    apb(1'b0, 6'h30, 8'h00);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    wr(ts_capture_pkg::IDX_STATUS, 8'hff);
    expect_reg("status", ts_capture_pkg::IDX_STATUS, 32'h0);
    wr(ts_capture_pkg::IDX_LINE_HI, 8'h00);
    wr(ts_capture_pkg::IDX_LINE_LO, 8'h03);
    pstrb <= 4'h0;
    wr(ts_capture_pkg::IDX_LINE_LO, 8'h55);
    pstrb <= 4'h1;
    expect_reg("line upper", ts_capture_pkg::IDX_LINE_HI, 32'h0);
    expect_reg("line lower", ts_capture_pkg::IDX_LINE_LO, 32'h3);
    for (int r = 0; r < 4; r++)
    begin
      rearm({2'b00, 2'(r), 4'h0}, 2'b11);
      run(2'b11, 1'b0, per[r], kk[r], 3);
      expect_reg("status", ts_capture_pkg::IDX_STATUS, 32'h13);
      expect_reg("p0 upper", ts_capture_pkg::IDX_P0_HI, kk[r] >> 8);
      expect_reg("p0 lower", ts_capture_pkg::IDX_P0_LO, kk[r] & 255);
      expect_reg("p1 upper", ts_capture_pkg::IDX_P1_HI, kk[r] >> 8);
      expect_reg("p1 lower", ts_capture_pkg::IDX_P1_LO, kk[r] & 255);
      wr(ts_capture_pkg::IDX_CONTROL, 8'h13);
      expect_reg("frozen", ts_capture_pkg::IDX_STATUS, 32'h03);
    end
    run(2'b11, 1'b0, 100, 1, 3);
    expect_reg("held", ts_capture_pkg::IDX_P0_LO, 32'h2);
    expect_reg("held st", ts_capture_pkg::IDX_STATUS, 32'h03);
    rearm(8'h00, 2'b01);
    run(2'b11, 1'b0, 4, 6, 3);
    expect_reg("one port", ts_capture_pkg::IDX_STATUS, 32'h11);
    expect_reg("p1 kept", ts_capture_pkg::IDX_P1_LO, 32'h2);
    expect_reg("p0 new", ts_capture_pkg::IDX_P0_LO, 32'h6);
    check("irq masked", {31'h0, irq}, 32'h0);
    expect_reg("irq status", ts_capture_pkg::IDX_IRQ_STS, 32'h13);
    wr(ts_capture_pkg::IDX_IRQ_MASK, 8'h11);
    check("irq raised", {31'h0, irq}, 32'h1);
    wr(ts_capture_pkg::IDX_IRQ_STS, 8'h13);
    check("irq cleared", {31'h0, irq}, 32'h0);
    expect_reg("irq status", ts_capture_pkg::IDX_IRQ_STS, 32'h0);
    edge_fall = 1'b1;
    frame_sync <= 1'b1;
    rearm(8'h40, 2'b11);
    run(2'b11, 1'b0, 4, 5, 3);
    expect_reg("falling", ts_capture_pkg::IDX_P1_LO, 32'h5);
    rearm(8'h41, 2'b11);
    run(2'b11, 1'b1, 4, 4, 3);
    expect_reg("frame mode", ts_capture_pkg::IDX_P0_LO, 32'h4);
    rearm(8'h03, 2'b11);
    pulse(2'b11, 2'b00);
    expect_reg("not armed", ts_capture_pkg::IDX_STATUS, 32'h0);
    repeat (3) pulse(2'b00, 2'b11);
    expect_reg("armed", ts_capture_pkg::IDX_STATUS, 32'h0);
    pulse(2'b11, 2'b00);
    expect_reg("free run", ts_capture_pkg::IDX_STATUS, 32'h13);
    final_report();
  end
endmodule
`default_nettype wire
